//--- core/fcp_decode.sv
// How it works
// - verify count flag turns length into sectors
// - fifo disable flag zero enables fifo
// - implied seek before cylinder read/write
// - extended flag widens tape reg, shows status b
// - interface flag zero tri-states drive outputs
// - two bits pick drive, high bit first
// - gap3 length parameter sets sector gap
// - perpendicular gap only in perpendicular mode
// - head address selects side zero or one
// - wait head load time before transfer
// - unload head after unload time elapses
// - alternate format flag selects track format
// - lock keeps fifo/threshold/precomp on soft reset
// - density one selects mfm encoding
// - sector bytes 128 shifted by size code; size code zero uses the length field
// - non-dma interrupts per byte, else dma
// - skip result flag skips result phase
// - end-of-track is last sector number
//
// Design decisions made here: strobed register access and the register addresses.
`timescale 1ns/100ps
`default_nettype none
module fcp_decode
  import fcp_pkg::*;
(
  input  wire logic              ref_clk,
  input  wire logic              rst_n,
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic [31:0]       reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [31:0]       reg_rdata,
  input  wire logic              dma_ack_n,
  output logic      [3:0]        drive_select_out,
  output logic      [3:0]        motor_enable_out,
  output logic                   drive_if_oe,
  output logic                   head_side_out,
  output logic                   head_load_out,
  output logic                   mfm_out,
  output logic                   dma_req,
  output logic                   irq,
  output logic                   fifo_enable,
  output logic                   tape_reg_ext,
  output logic                   status_b_visible,
  output logic                   alt_format_out,
  output logic                   perp_gap_out,
  output logic      [7:0]        gap3_length_out,
  output logic      [14:0]       xfer_len_out,
  output logic      [7:0]        last_sector_out,
  output logic      [7:0]        sector_out
);
  fcp_cmd_type   cmd_q;
  fcp_cfg_type   cfg_q;
  fcp_phase_type phase_q;
  logic [7:0]    dtl_q;
  logic [7:0]    load_time_q;
  logic [7:0]    unload_time_q;
  logic [7:0]    sector_q;
  logic [IRQ_W-1:0] irq_stat_q;
  logic [IRQ_W-1:0] irq_mask_q;
  logic [IRQ_W-1:0] irq_evt;
  logic [15:0]   seek_cnt_q;
  logic          ack_s;
  logic          ack_prev_q;
  logic          byte_evt;
  logic          wr_cmd;
  logic          wr_ctl;
  logic          soft_rst;
  logic          exec_end;
  logic          byte_xfer;
  logic          load_done;
  logic          unload_done;
  logic          load_start;
  logic          unload_start;
  logic          seek_done;

  assign wr_cmd    = reg_wr && reg_addr == OFF_CMD && phase_q == PH_IDLE;
  assign wr_ctl    = reg_wr && reg_addr == OFF_CONTROL;
  assign soft_rst  = wr_ctl && reg_wdata[CTL_SOFT_RST];
  assign exec_end  = (wr_ctl && reg_wdata[CTL_EXEC_END]) ||
                     (phase_q == PH_EXEC && sector_q == cmd_q.last_sector_number
                      && byte_evt);
  assign byte_xfer = wr_ctl && reg_wdata[CTL_BYTE_XFER];

  fcp_sync u_ack_sync
  (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .d       (~dma_ack_n),
    .q       (ack_s)
  );

  always_ff @(posedge ref_clk or negedge rst_n)
    if (!rst_n)
      ack_prev_q <= 1'b0;
    else
      ack_prev_q <= ack_s;

  // one byte per host strobe or per dma acknowledge
  assign byte_evt = phase_q == PH_EXEC &&
                    (cmd_q.non_dma_flag ? byte_xfer : (ack_s && !ack_prev_q));

  // command captured only while idle, so it holds through execution
  always_ff @(posedge ref_clk or negedge rst_n)
    if (!rst_n)
    begin
      cmd_q <= '0;
      dtl_q <= DTL_UNUSED;
    end
    else if (wr_cmd)
    begin
      cmd_q <= fcp_cmd_type'({reg_wdata[31:24], reg_wdata[23:16],
                             (reg_wdata[14:12] > SIZE_CODE_MAX) ? SIZE_CODE_MAX
                               : reg_wdata[14:12],
                             reg_wdata[CMD_HAS_CYL], reg_wdata[CMD_VERIFY],
                             reg_wdata[CMD_RW], reg_wdata[CMD_PERP_GAP],
                             reg_wdata[CMD_SKIP_RES], reg_wdata[CMD_NON_DMA],
                             reg_wdata[CMD_MFM], reg_wdata[CMD_HEAD],
                             reg_wdata[CMD_DRIVE_HI], reg_wdata[CMD_DRIVE_LO]});
    end
    else if (reg_wr && reg_addr == OFF_XFER && phase_q == PH_IDLE)
      dtl_q <= reg_wdata[7:0];

  // lock shields fifo fields from soft reset
  always_ff @(posedge ref_clk or negedge rst_n)
    if (!rst_n)
    begin
      cfg_q <= '0;
      cfg_q.fifo_disable_flag   <= FIFO_DIS_RST;
      cfg_q.fifo_threshold      <= FIFO_THR_RST;
      cfg_q.precomp_start_track <= PRECOMP_RST;
    end
    else if (reg_wr && reg_addr == OFF_CFG)
      cfg_q <= fcp_cfg_type'({reg_wdata[CFG_VERIFY_COUNT],
                              reg_wdata[CFG_FIFO_DISABLE],
                              reg_wdata[CFG_IMPLIED_SEEK],
                              reg_wdata[CFG_EXT_REG],
                              reg_wdata[CFG_DRV_IF_EN],
                              reg_wdata[CFG_ALT_FORMAT],
                              reg_wdata[CFG_LOCK],
                              reg_wdata[CFG_PERP_MODE],
                              reg_wdata[CFG_FIFO_THR_LSB +: 4],
                              reg_wdata[CFG_PRECOMP_LSB +: 8]});
    else if (soft_rst && !cfg_q.lock)
    begin
      cfg_q.fifo_disable_flag   <= FIFO_DIS_RST;
      cfg_q.fifo_threshold      <= FIFO_THR_RST;
      cfg_q.precomp_start_track <= PRECOMP_RST;
    end

  always_ff @(posedge ref_clk or negedge rst_n)
    if (!rst_n)
    begin
      load_time_q   <= 8'h01;
      unload_time_q <= 8'h01;
    end
    else if (reg_wr && reg_addr == OFF_TIMING)
    begin
      load_time_q   <= reg_wdata[7:0];
      unload_time_q <= reg_wdata[15:8];
    end

  assign load_start   = (wr_cmd && reg_wdata[CMD_RW] &&
                         !(cfg_q.implied_seek_enable && reg_wdata[CMD_HAS_CYL]))
                        || seek_done;
  assign unload_start = phase_q == PH_EXEC && exec_end;

  fcp_timer u_load_timer
  (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .start   (load_start),
    .units   (load_time_q),
    .done    (load_done)
  );

  fcp_timer u_unload_timer
  (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .start   (unload_start),
    .units   (unload_time_q),
    .done    (unload_done)
  );

  assign seek_done = phase_q == PH_SEEK && seek_cnt_q == 16'h0000;

  always_ff @(posedge ref_clk or negedge rst_n)
    if (!rst_n)
      seek_cnt_q <= 16'h0000;
    else if (wr_cmd)
      seek_cnt_q <= 16'(SEEK_CYC - 1);
    else if (phase_q == PH_SEEK && seek_cnt_q != 16'h0000)
      seek_cnt_q <= seek_cnt_q - 16'h0001;

  always_ff @(posedge ref_clk or negedge rst_n)
    if (!rst_n)
      phase_q <= PH_IDLE;
    else if (soft_rst)
      phase_q <= PH_IDLE;
    else
      unique case (phase_q)
        PH_IDLE:
          if (wr_cmd && reg_wdata[CMD_RW])
            phase_q <= (cfg_q.implied_seek_enable && reg_wdata[CMD_HAS_CYL])
                       ? PH_SEEK : PH_LOAD;
        PH_SEEK:
          if (seek_done)
            phase_q <= PH_LOAD;
        PH_LOAD:
          if (load_done)
            phase_q <= PH_EXEC;
        PH_EXEC:
          if (exec_end)
            phase_q <= cmd_q.skip_result_flag ? PH_IDLE : PH_RESULT;
        PH_RESULT:
          if (reg_rd && reg_addr == OFF_STATUS)
            phase_q <= PH_IDLE;
      endcase

  // sector sequencing up to end-of-track
  always_ff @(posedge ref_clk or negedge rst_n)
    if (!rst_n)
      sector_q <= 8'h01;
    else if (reg_wr && reg_addr == OFF_SECTOR && phase_q == PH_IDLE)
      sector_q <= reg_wdata[7:0];
    else if (byte_evt && sector_q != cmd_q.last_sector_number)
      sector_q <= sector_q + 8'h01;

  always_ff @(posedge ref_clk or negedge rst_n)
    if (!rst_n)
      head_load_out <= 1'b0;
    else if (load_start)
      head_load_out <= 1'b1;
    else if (unload_done)
      head_load_out <= 1'b0;

  assign irq_evt = {seek_done, byte_evt && cmd_q.non_dma_flag, unload_start};

  // set wins over write-one clear
  always_ff @(posedge ref_clk or negedge rst_n)
    if (!rst_n)
      irq_stat_q <= '0;
    else if (reg_wr && reg_addr == OFF_IRQ_STAT)
      irq_stat_q <= (irq_stat_q & ~reg_wdata[IRQ_W-1:0]) | irq_evt;
    else
      irq_stat_q <= irq_stat_q | irq_evt;

  always_ff @(posedge ref_clk or negedge rst_n)
    if (!rst_n)
      irq_mask_q <= '0;
    else if (reg_wr && reg_addr == OFF_IRQ_MASK)
      irq_mask_q <= reg_wdata[IRQ_W-1:0];

  always_ff @(posedge ref_clk or negedge rst_n)
    if (!rst_n)
      irq <= 1'b0;
    else
      irq <= |(irq_stat_q & irq_mask_q);

  always_ff @(posedge ref_clk or negedge rst_n)
    if (!rst_n)
      dma_req <= 1'b0;
    else
      dma_req <= phase_q == PH_EXEC && !cmd_q.non_dma_flag && !ack_s;

  // drive side outputs
  always_ff @(posedge ref_clk or negedge rst_n)
    if (!rst_n)
    begin
      drive_select_out <= 4'h0;
      motor_enable_out <= 4'h0;
      drive_if_oe      <= 1'b0;
      head_side_out    <= 1'b0;
      mfm_out          <= 1'b0;
    end
    else
    begin
      // remapping of boot drive deliberately ignored here
      drive_select_out <= 4'h1 << {cmd_q.drive[1], cmd_q.drive[0]};
      motor_enable_out <= (phase_q != PH_IDLE || head_load_out)
                          ? (4'h1 << {cmd_q.drive[1], cmd_q.drive[0]})
                          : 4'h0;
      drive_if_oe      <= cfg_q.drive_interface_drive_enable;
      head_side_out    <= cmd_q.head_address;
      mfm_out          <= cmd_q.mfm;
    end

  always_ff @(posedge ref_clk or negedge rst_n)
    if (!rst_n)
    begin
      fifo_enable      <= 1'b0;
      tape_reg_ext     <= 1'b0;
      status_b_visible <= 1'b0;
      alt_format_out   <= 1'b0;
      perp_gap_out     <= 1'b0;
      gap3_length_out  <= 8'h00;
      last_sector_out  <= 8'h00;
      sector_out       <= 8'h00;
      xfer_len_out     <= 15'h0000;
    end
    else
    begin
      fifo_enable      <= !cfg_q.fifo_disable_flag;
      tape_reg_ext     <= cfg_q.extended_register_enable;
      status_b_visible <= cfg_q.extended_register_enable;
      alt_format_out   <= cfg_q.alt_format;
      perp_gap_out     <= cfg_q.perp_mode && cmd_q.perp_gap;
      gap3_length_out  <= cmd_q.gap3_length;
      last_sector_out  <= cmd_q.last_sector_number;
      sector_out       <= sector_q;
      // verify count: length field reused as sector count
      if (cmd_q.verify && cfg_q.verify_count_enable)
        xfer_len_out <= {7'h00, dtl_q};
      else if (cmd_q.size_code == 3'h0)
        xfer_len_out <= {7'h00, dtl_q};
      else
        xfer_len_out <= 15'(BASE_SECTOR_BYTES) << cmd_q.size_code;
    end

  always_ff @(posedge ref_clk or negedge rst_n)
    if (!rst_n)
      reg_rdata <= 32'h0000_0000;
    else if (reg_rd)
      unique case (reg_addr)
        OFF_CMD:      reg_rdata <= {cmd_q.last_sector_number, cmd_q.gap3_length,
                                    1'b0, cmd_q.size_code, 2'b00,
                                    cmd_q.has_cylinder, cmd_q.verify, cmd_q.rw,
                                    cmd_q.perp_gap, cmd_q.skip_result_flag,
                                    cmd_q.non_dma_flag, cmd_q.mfm,
                                    cmd_q.head_address, cmd_q.drive};
        OFF_CFG:      reg_rdata <= {8'h00, cfg_q.precomp_start_track, 4'h0,
                                    cfg_q.fifo_threshold, cfg_q.perp_mode,
                                    cfg_q.lock, cfg_q.alt_format,
                                    cfg_q.drive_interface_drive_enable,
                                    cfg_q.extended_register_enable,
                                    cfg_q.implied_seek_enable,
                                    cfg_q.fifo_disable_flag,
                                    cfg_q.verify_count_enable};
        OFF_XFER:     reg_rdata <= {24'h000000, dtl_q};
        OFF_TIMING:   reg_rdata <= {16'h0000, unload_time_q, load_time_q};
        OFF_STATUS:   reg_rdata <= {28'h0000000, phase_q == PH_SEEK,
                                    phase_q == PH_RESULT, head_load_out,
                                    phase_q != PH_IDLE};
        OFF_IRQ_STAT: reg_rdata <= {29'h0000000, irq_stat_q};
        OFF_IRQ_MASK: reg_rdata <= {29'h0000000, irq_mask_q};
        OFF_SECTOR:   reg_rdata <= {24'h000000, sector_q};
        default:      reg_rdata <= 32'h0000_0000;
      endcase
    else
      reg_rdata <= 32'h0000_0000;
endmodule
`default_nettype wire

//--- core/fcp_pkg.sv
package fcp_pkg;

  // register port
  localparam int          ADDR_W            = 4;
  localparam logic [3:0]  OFF_CMD           = 4'h0;
  localparam logic [3:0]  OFF_CFG           = 4'h1;
  localparam logic [3:0]  OFF_XFER          = 4'h2;
  localparam logic [3:0]  OFF_TIMING        = 4'h3;
  localparam logic [3:0]  OFF_STATUS        = 4'h4;
  localparam logic [3:0]  OFF_IRQ_STAT      = 4'h5;
  localparam logic [3:0]  OFF_IRQ_MASK      = 4'h6;
  localparam logic [3:0]  OFF_CONTROL       = 4'h7;
  localparam logic [3:0]  OFF_SECTOR        = 4'h8;

  // configuration word fields (OFF_CFG)
  localparam int CFG_VERIFY_COUNT    = 0;
  localparam int CFG_FIFO_DISABLE    = 1;
  localparam int CFG_IMPLIED_SEEK    = 2;
  localparam int CFG_EXT_REG         = 3;
  localparam int CFG_DRV_IF_EN       = 4;
  localparam int CFG_ALT_FORMAT      = 5;
  localparam int CFG_LOCK            = 6;
  localparam int CFG_PERP_MODE       = 7;
  localparam int CFG_FIFO_THR_LSB    = 8;
  localparam int CFG_PRECOMP_LSB     = 16;

  // reset values
  localparam logic [3:0] FIFO_THR_RST    = 4'h0;
  localparam logic [7:0] PRECOMP_RST     = 8'h00;
  localparam logic       FIFO_DIS_RST    = 1'b1;
  localparam logic [7:0] DTL_UNUSED      = 8'hFF;

  // command byte fields (OFF_CMD)
  localparam int CMD_DRIVE_LO    = 0;
  localparam int CMD_DRIVE_HI    = 1;
  localparam int CMD_HEAD        = 2;
  localparam int CMD_MFM         = 3;
  localparam int CMD_NON_DMA     = 4;
  localparam int CMD_SKIP_RES    = 5;
  localparam int CMD_PERP_GAP    = 6;
  localparam int CMD_RW          = 7;
  localparam int CMD_VERIFY      = 8;
  localparam int CMD_HAS_CYL     = 9;
  localparam int CMD_SIZE_LSB    = 12;
  localparam int CMD_GAP3_LSB    = 16;
  localparam int CMD_EOT_LSB     = 24;

  // sector-size code limits
  localparam logic [2:0] SIZE_CODE_MAX = 3'h7;
  localparam int         BASE_SECTOR_BYTES = 128;

  // status bits
  localparam int ST_BUSY       = 0;
  localparam int ST_HEAD_LOAD  = 1;
  localparam int ST_RESULT     = 2;
  localparam int ST_SEEK       = 3;

  // interrupt events
  localparam int IRQ_DONE      = 0;
  localparam int IRQ_BYTE      = 1;
  localparam int IRQ_SEEK      = 2;
  localparam int IRQ_W         = 3;

  // control register bits
  localparam int CTL_SOFT_RST  = 0;
  localparam int CTL_EXEC_END  = 1;
  localparam int CTL_BYTE_XFER = 2;

  // timing: one head-time unit in ns
  localparam int CLK_PERIOD_NS = 4;
  localparam int HEAD_UNIT_NS  = 1000;
  localparam int HEAD_UNIT_CYC = HEAD_UNIT_NS / CLK_PERIOD_NS;
  localparam int SEEK_NS       = 1000;
  localparam int SEEK_CYC      = (SEEK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [2:0] {
    PH_IDLE,
    PH_SEEK,
    PH_LOAD,
    PH_EXEC,
    PH_RESULT
  } fcp_phase_type;

  typedef struct packed {
    logic [7:0] last_sector_number;
    logic [7:0] gap3_length;
    logic [2:0] size_code;
    logic       has_cylinder;
    logic       verify;
    logic       rw;
    logic       perp_gap;
    logic       skip_result_flag;
    logic       non_dma_flag;
    logic       mfm;
    logic       head_address;
    logic [1:0] drive;
  } fcp_cmd_type;

  typedef struct packed {
    logic       verify_count_enable;
    logic       fifo_disable_flag;
    logic       implied_seek_enable;
    logic       extended_register_enable;
    logic       drive_interface_drive_enable;
    logic       alt_format;
    logic       lock;
    logic       perp_mode;
    logic [3:0] fifo_threshold;
    logic [7:0] precomp_start_track;
  } fcp_cfg_type;

endpackage

//--- core/fcp_timer.sv
`timescale 1ns/100ps
`default_nettype none
module fcp_timer
  import fcp_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic       rst_n,
  input  wire logic       start,
  input  wire logic [7:0] units,
  output logic            done
);
  logic [7:0]  unit_q;
  logic [15:0] tick_q;
  logic        run_q;

  always_ff @(posedge ref_clk or negedge rst_n)
    if (!rst_n)
    begin
      run_q  <= 1'b0;
      unit_q <= 8'h00;
      tick_q <= 16'h0000;
      done   <= 1'b0;
    end
    else
    begin
      done <= 1'b0;
      if (start)
      begin
        run_q  <= 1'b1;
        unit_q <= units;
        tick_q <= 16'(HEAD_UNIT_CYC - 1);
      end
      else if (run_q)
      begin
        if (unit_q == 8'h00)
        begin
          run_q <= 1'b0;
          done  <= 1'b1;
        end
        else if (tick_q == 16'h0000)
        begin
          tick_q <= 16'(HEAD_UNIT_CYC - 1);
          unit_q <= unit_q - 8'h01;
        end
        else
          tick_q <= tick_q - 16'h0001;
      end
    end
endmodule
`default_nettype wire

//--- core/fcp_sync.sv
`timescale 1ns/100ps
`default_nettype none
module fcp_sync
(
  input  wire logic ref_clk,
  input  wire logic rst_n,
  input  wire logic d,
  output logic      q
);
  logic meta_q;

  // first stage feeds only the second
  always_ff @(posedge ref_clk or negedge rst_n)
    if (!rst_n)
    begin
      meta_q <= 1'b0;
      q      <= 1'b0;
    end
    else
    begin
      meta_q <= d;
      q      <= meta_q;
    end
endmodule
`default_nettype wire

//--- verif/fcp_decode_assertions.sv
`timescale 1ns/100ps
`default_nettype none
module fcp_decode_checker
  import fcp_pkg::*;
(
  input wire logic              ref_clk,
  input wire logic              rst_n,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [31:0]       reg_wdata,
  input wire logic              reg_wr,
  input wire logic              reg_rd,
  input wire logic [31:0]       reg_rdata,
  input wire logic              dma_ack_n,
  input wire logic [3:0]        drive_select_out,
  input wire logic [3:0]        motor_enable_out,
  input wire logic              drive_if_oe,
  input wire logic              head_load_out,
  input wire logic              dma_req,
  input wire logic              fifo_enable,
  input wire logic              tape_reg_ext,
  input wire logic              status_b_visible,
  input wire logic [7:0]        gap3_length_out
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);
  logic cfg_wr;
  assign cfg_wr = reg_wr && (reg_addr == OFF_CFG);
  AST_RDATA_IDLE:
  assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data seen without a read");
  AST_FIFO_EN:
  assert property (cfg_wr |-> ##2
    fifo_enable == !$past(reg_wdata[CFG_FIFO_DISABLE], 2))
    else $error("fifo enable does not follow config");
  AST_DRV_IF:
  assert property (cfg_wr |-> ##2
    drive_if_oe == $past(reg_wdata[CFG_DRV_IF_EN], 2))
    else $error("drive interface enable does not follow config");
  AST_EXT_REG:
  assert property (cfg_wr |-> ##2 (tape_reg_ext == status_b_visible)
    && tape_reg_ext == $past(reg_wdata[CFG_EXT_REG], 2))
    else $error("extended register view wrong");
  AST_DRV_ONEHOT:
  assert property ($onehot0(drive_select_out))
    else $error("more than one drive selected");
  AST_MOTOR_DRV:
  assert property (motor_enable_out != 4'h0
    |-> motor_enable_out == drive_select_out)
    else $error("motor enable on another drive");
  AST_HOLD_EXEC:
  assert property (reg_wr && reg_addr == OFF_CMD && dma_req
    |-> ##2 gap3_length_out == $past(gap3_length_out, 2))
    else $error("parameter changed during execution");
  AST_ACK_DROP:
  assert property ($fell(dma_ack_n) |-> ##[1:6] !dma_req)
    else $error("request not withdrawn after acknowledge");
  AST_REQ_LOADED:
  assert property (dma_req |-> head_load_out)
    else $error("transfer requested with head unloaded");
  cover property ($rose(dma_req));
  cover property ($fell(head_load_out));
  cover property (reg_wr && reg_addr == OFF_CMD && dma_req);
endmodule
bind fcp_decode fcp_decode_checker u_chk (
  .ref_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
  .dma_ack_n, .drive_select_out, .motor_enable_out, .drive_if_oe,
  .head_load_out, .dma_req, .fifo_enable, .tape_reg_ext,
  .status_b_visible, .gap3_length_out);
`default_nettype wire

//--- verif/fcp_dma_model.sv
`timescale 1ns/100ps
`default_nettype none
module fcp_dma_model
(
  input  wire logic       ref_clk,
  input  wire logic       rst_n,
  input  wire logic       dma_req,
  input  wire logic [3:0] lat,
  output logic            dma_ack_n,
  output logic      [7:0] acks
);
  logic [4:0] cnt_q;
  // holdoff after each ack lets the synced request fall first
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_q <= 5'h00;
      dma_ack_n <= 1'b1;
      acks <= 8'h00;
    end
    else if (cnt_q == 5'h00)
    begin
      dma_ack_n <= 1'b1;
      if (dma_req)
        cnt_q <= {1'b0, lat} + 5'h10;
    end
    else
    begin
      cnt_q <= cnt_q - 5'h01;
      dma_ack_n <= (cnt_q != 5'h10);
      if (cnt_q == 5'h10)
        acks <= acks + 8'h01;
    end
  end
endmodule
`default_nettype wire

//--- verif/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import fcp_pkg::*;
  typedef struct packed {
    logic [31:0] cmd;
    logic [3:0]  dsel;
    logic [14:0] xlen;
  } fcp_row_type;
  logic        ref_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [3:0]  reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [3:0]  lat = 4'hC;
  logic [31:0] rdv, rdata;
  logic [7:0]  acks, gap3, last_s, sect;
  logic [3:0]  dsel, motor;
  logic [14:0] xlen;
  logic        dma_ack_n, oe, side, hl, mfm, req, irq, fen, ext, sb, alt, pg;
  int          n_mismatch = 0;
  int          n_checks = 0;
  int          cyc;
  fcp_row_type rows [4];
  always #2 ref_clk = ~ref_clk;
  fcp_decode dut (.ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(rdata), .dma_ack_n(dma_ack_n), .drive_select_out(dsel),
    .motor_enable_out(motor), .drive_if_oe(oe), .head_side_out(side),
    .head_load_out(hl), .mfm_out(mfm), .dma_req(req), .irq(irq),
    .fifo_enable(fen), .tape_reg_ext(ext), .status_b_visible(sb),
    .alt_format_out(alt), .perp_gap_out(pg), .gap3_length_out(gap3),
    .xfer_len_out(xlen), .last_sector_out(last_s), .sector_out(sect));
  fcp_dma_model u_dma (.ref_clk(ref_clk), .rst_n(rst_n), .dma_req(req),
    .lat(lat), .dma_ack_n(dma_ack_n), .acks(acks));
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    n_checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 rdv = rdata;
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic wait_acks(input logic [7:0] n);
    cyc = 0;
    while (acks < n && cyc < 2000)
    begin
      step(1);
      cyc++;
    end
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // whole run is under two thousand cycles
  initial
  begin
    repeat (20000) @(posedge ref_clk);
    n_mismatch++;
    summarize();
  end
  initial
  begin
    rows[0] = '{32'h0A1B1040, 4'h1, 15'd256};
    rows[1] = '{32'h122A704D, 4'h2, 15'd16384};
    rows[2] = '{32'h05330002, 4'h4, 15'd64};
    rows[3] = '{32'h09442103, 4'h8, 15'd64};
    repeat (20) @(posedge ref_clk);
    rst_n <= 1'b1;
    step(2);
    chk("fifo_enable", fen, 0);
    chk("drive_if_oe", oe, 0);
    rd(OFF_CFG);
    chk("cfg", rdv, 32'h2);
    rd(OFF_TIMING);
    chk("timing", rdv, 32'h101);
    rd(4'hF);
    chk("unmapped", rdv, 0);
    $display("test reset done");
    wr(OFF_CFG, 32'h30);
    step(3);
    chk("fifo_enable", fen, 1);
    chk("drive_if_oe", oe, 1);
    chk("alt_format", alt, 1);
    wr(OFF_CFG, 32'h0B);
    step(3);
    chk("alt_format", alt, 0);
    chk("tape_reg_ext", ext, 1);
    chk("status_b", sb, 1);
    wr(OFF_XFER, 32'h40);
    foreach (rows[i])
    begin
      wr(OFF_CMD, rows[i].cmd);
      step(3);
      chk("drive_select", dsel, rows[i].dsel);
      chk("head_side", side, rows[i].cmd[CMD_HEAD]);
      chk("mfm", mfm, rows[i].cmd[CMD_MFM]);
      chk("perp_gap", pg, 0);
      chk("gap3", gap3, rows[i].cmd[23:16]);
      chk("last_sector", last_s, rows[i].cmd[31:24]);
      chk("xfer_len", xlen, rows[i].xlen);
    end
    $display("test table done");
    wr(OFF_CFG, 32'h9C);
    wr(OFF_IRQ_MASK, 32'h1);
    wr(OFF_SECTOR, 32'h3);
    wr(OFF_CMD, 32'h052A12C1);
    cyc = 0;
    while (req !== 1'b1 && cyc < 1000)
    begin
      step(1);
      cyc++;
    end
    chk("req_delay", cyc >= SEEK_CYC + HEAD_UNIT_CYC
      && cyc <= SEEK_CYC + HEAD_UNIT_CYC + 8, 1);
    wr(OFF_CMD, 32'h07FF00C1);
    step(2);
    chk("gap3_held", gap3, 8'h2A);
    chk("perp_gap", pg, 1);
    chk("motor", motor, 4'h2);
    wait_acks(1);
    lat <= 4'h1;
    wait_acks(3);
    step(30);
    chk("acks", acks, 3);
    rd(OFF_STATUS);
    chk("status", rdv, 32'h7);
    chk("sector", sect, 8'h05);
    chk("irq", irq, 1);
    rd(OFF_IRQ_STAT);
    chk("irq_stat", rdv, 32'h5);
    wr(OFF_IRQ_STAT, 32'h5);
    step(2);
    chk("irq", irq, 0);
    step(400);
    chk("head_load", hl, 0);
    $display("test dma done");
    wr(OFF_IRQ_MASK, 32'h0);
    wr(OFF_SECTOR, 32'h5);
    wr(OFF_CMD, 32'h052A10B3);
    step(HEAD_UNIT_CYC + 20);
    chk("dma_req", req, 0);
    chk("head_load", hl, 1);
    wr(OFF_CONTROL, 32'h4);
    step(2);
    rd(OFF_STATUS);
    chk("result", rdv[ST_RESULT], 0);
    chk("irq_masked", irq, 0);
    rd(OFF_IRQ_STAT);
    chk("irq_stat", rdv, 32'h3);
    wr(OFF_IRQ_MASK, 32'h2);
    step(2);
    chk("irq", irq, 1);
    step(HEAD_UNIT_CYC - 40);
    chk("head_load", hl, 1);
    step(60);
    chk("head_load", hl, 0);
    $display("test host byte done");
    wr(OFF_CFG, 32'h0510);
    step(3);
    wr(OFF_CONTROL, 32'h1);
    step(3);
    rd(OFF_CFG);
    chk("cfg_unlocked", rdv, 32'h12);
    wr(OFF_CFG, 32'h0550);
    step(3);
    wr(OFF_CONTROL, 32'h1);
    step(3);
    rd(OFF_CFG);
    chk("cfg_locked", rdv, 32'h550);
    chk("fifo_enable", fen, 1);
    $display("test soft reset done");
    summarize();
  end
endmodule
`default_nettype wire
